// >>> rtl/kwsr_pkg.sv
// constants and types of the key wakeup stop release block
package kwsr_pkg;

    localparam int DW = 32;
    localparam int AW = 8;
    localparam int NKEY = 4;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_KEY_EN = 6'h31;
    localparam logic [5:0] IDX_CTRL = 6'h32;
    localparam logic [5:0] IDX_STAT = 6'h33;
    localparam logic [5:0] IDX_MASK = 6'h34;
    localparam logic [5:0] IDX_STATE = 6'h35;

    // enable register: key pins five..two at bits 7..4
    localparam int KEY_EN_LSB = 4;
    localparam logic [3:0] KEY_EN_RST = 4'h0;

    // control register fields
    localparam int CTRL_LEVEL_BIT = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    localparam logic CTRL_LEVEL_RST = 1'h1;

    // status and mask fields
    localparam int STAT_WAKE_BIT = 0;
    localparam int STAT_SKIP_BIT = 1;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // state register fields
    localparam int ST_STOP_BIT = 0;
    localparam int ST_WARM_BIT = 1;
    localparam int ST_REQ_BIT = 2;
    localparam int ST_PIN_BIT = 3;
    localparam int ST_KEY_LSB = 4;

    // warm-up length in core clock cycles
    localparam logic [3:0] WARM_CYC = 4'h8;
    localparam logic [3:0] WARM_LOAD = WARM_CYC - 4'h1;

    typedef enum logic [1:0] {
        KWSR_ACTIVE,
        KWSR_STOP,
        KWSR_WARMUP
    } kwsr_state_t;

endpackage

// >>> rtl/kwsr_wake_if.sv
// wake condition signals between the top and the release detector
`timescale 1ns/1ps
interface kwsr_wake_if;
    logic [kwsr_pkg::NKEY-1:0] key_level;
    logic [kwsr_pkg::NKEY-1:0] key_en;
    logic rel_pin;
    logic rel_prev;
    logic level_mode;
    logic [kwsr_pkg::NKEY-1:0] key_hit;
    logic release_req;
    logic entry_hit;

    modport det (
        input key_level,
        input key_en,
        input rel_pin,
        input rel_prev,
        input level_mode,
        output key_hit,
        output release_req,
        output entry_hit
    );

    modport ctl (
        output key_level,
        output key_en,
        output rel_pin,
        output rel_prev,
        output level_mode,
        input key_hit,
        input release_req,
        input entry_hit
    );
endinterface

// >>> rtl/kwsr_release_det.sv
// clockless release decision from the dedicated pin and the key pins
`timescale 1ns/1ps
module kwsr_release_det (
    kwsr_wake_if.det bus
);

    wire any_key;
    wire pin_edge;
    wire pin_cond;

    // ****************************************
    // per key pin low-level detect
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < kwsr_pkg::NKEY; g++) begin : g_key
            // only an enabled key pin held low counts
            assign bus.key_hit[g] = bus.key_en[g] & ~bus.key_level[g];
        end
    endgenerate

    assign any_key = |bus.key_hit;

    // ****************************************
    // dedicated pin, level or rising edge
    // ****************************************
    assign pin_edge = bus.rel_pin & ~bus.rel_prev;
    assign pin_cond = bus.level_mode ? bus.rel_pin : pin_edge;

    // purely combinational so it holds while the core clock is stopped
    assign bus.release_req = pin_cond | any_key;

    // condition present at sleep entry, checked as a level
    assign bus.entry_hit = bus.rel_pin | any_key;

endmodule

// >>> rtl/kwsr_top.sv
// key wakeup stop release block with its avalon register slave
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps

module kwsr_top (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [kwsr_pkg::AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [kwsr_pkg::DW-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [kwsr_pkg::DW-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_release_pin,
    input wire logic [kwsr_pkg::NKEY-1:0] i_key_wake_pin,
    output logic o_stop_mode,
    output logic o_warmup,
    output logic o_wake_req,
    output logic o_irq
);

    // ****************************************
    // state
    // ****************************************
    kwsr_pkg::kwsr_state_t state;
    kwsr_pkg::kwsr_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [kwsr_pkg::NKEY-1:0] key_en;
    logic level_mode;
    logic [1:0] stat;
    logic [1:0] next_stat;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic rel_prev;
    logic [kwsr_pkg::NKEY-1:0] key_sample;
    logic pin_sample;
    logic key_written;

    kwsr_wake_if wake ();

    kwsr_release_det u_det (
        .bus(wake.det)
    );

    assign wake.key_level = i_key_wake_pin;
    assign wake.key_en = key_en;
    assign wake.rel_pin = i_release_pin;
    assign wake.rel_prev = rel_prev;
    assign wake.level_mode = level_mode;

    // ****************************************
    // avalon decode
    // ****************************************
    wire bus_req = i_avs_read | i_avs_write;
    wire accept = bus_req & o_avs_waitrequest;
    wire done = bus_req & ~o_avs_waitrequest;
    wire [5:0] idx = i_avs_address[kwsr_pkg::AW-1:2];
    wire aligned = (i_avs_address[1:0] == 2'h0);
    wire hit_key_en = aligned & (idx == kwsr_pkg::IDX_KEY_EN);
    wire hit_ctrl = aligned & (idx == kwsr_pkg::IDX_CTRL);
    wire hit_stat = aligned & (idx == kwsr_pkg::IDX_STAT);
    wire hit_mask = aligned & (idx == kwsr_pkg::IDX_MASK);
    wire hit_state = aligned & (idx == kwsr_pkg::IDX_STATE);
    wire wr_lane0 = done & i_avs_write & i_avs_byteenable[0];
    wire wr_key_en = wr_lane0 & hit_key_en;
    wire wr_ctrl = wr_lane0 & hit_ctrl;
    wire wr_stat = wr_lane0 & hit_stat;
    wire wr_mask = wr_lane0 & hit_mask;
    wire [7:0] wbyte = i_avs_writedata[7:0];

    // a write of one to the sleep bit is the stop entry instruction
    wire sleep_go = wr_ctrl & wbyte[kwsr_pkg::CTRL_SLEEP_BIT];
    wire in_active = (state == kwsr_pkg::KWSR_ACTIVE);
    wire in_stop = (state == kwsr_pkg::KWSR_STOP);

    // ****************************************
    // read mux
    // ****************************************
    wire [7:0] ctrl_view = {7'h00, level_mode};
    wire [7:0] stat_view = {6'h00, stat};
    wire [7:0] mask_view = {6'h00, mask};
    wire [7:0] state_view = {key_sample, pin_sample, o_wake_req,
                             o_warmup, o_stop_mode};
    // enable register is write only and reads back zero
    wire [7:0] rd_byte = hit_ctrl ? ctrl_view :
                         hit_stat ? stat_view :
                         hit_mask ? mask_view :
                         hit_state ? state_view : 8'h00;

    // ****************************************
    // bus slave, one wait state
    // ****************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'h1;
        end else begin
            o_avs_waitrequest <= ~accept;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (accept & i_avs_read) begin
            o_avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            key_en <= kwsr_pkg::KEY_EN_RST;
        end else if (wr_key_en) begin
            key_en <= wbyte[7:kwsr_pkg::KEY_EN_LSB];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            level_mode <= kwsr_pkg::CTRL_LEVEL_RST;
        end else if (wr_ctrl) begin
            level_mode <= wbyte[kwsr_pkg::CTRL_LEVEL_BIT];
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    wire ev_wake = in_stop & wake.release_req;
    wire ev_skip = in_active & sleep_go & wake.entry_hit;
    wire [1:0] ev = {ev_skip, ev_wake};
    wire [1:0] clr = wr_stat ? wbyte[1:0] : 2'h0;

    // a new event wins over a clear in the same cycle
    assign next_stat = (stat & ~clr) | ev;
    assign next_mask = wr_mask ? wbyte[1:0] : mask;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stat <= kwsr_pkg::STAT_RST;
            mask <= kwsr_pkg::MASK_RST;
            o_irq <= 1'h0;
        end else begin
            stat <= next_stat;
            mask <= next_mask;
            o_irq <= |(next_stat & next_mask);
        end
    end

    // ****************************************
    // stop sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            kwsr_pkg::KWSR_ACTIVE: begin
                if (sleep_go) begin
                    next_cnt = kwsr_pkg::WARM_LOAD;
                    if (wake.entry_hit) begin
                        next_state = kwsr_pkg::KWSR_WARMUP;
                    end else begin
                        next_state = kwsr_pkg::KWSR_STOP;
                    end
                end
            end
            kwsr_pkg::KWSR_STOP: begin
                if (wake.release_req) begin
                    next_state = kwsr_pkg::KWSR_WARMUP;
                    next_cnt = kwsr_pkg::WARM_LOAD;
                end
            end
            kwsr_pkg::KWSR_WARMUP: begin
                if (cnt == 4'h0) begin
                    next_state = kwsr_pkg::KWSR_ACTIVE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                next_state = kwsr_pkg::KWSR_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= kwsr_pkg::KWSR_ACTIVE;
            cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_stop_mode <= 1'h0;
            o_warmup <= 1'h0;
            o_wake_req <= 1'h0;
        end else begin
            o_stop_mode <= (next_state == kwsr_pkg::KWSR_STOP);
            o_warmup <= (next_state == kwsr_pkg::KWSR_WARMUP);
            o_wake_req <= wake.release_req;
        end
    end

    // ****************************************
    // pin history and level snapshot
    // ****************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rel_prev <= 1'h0;
            key_sample <= 4'h0;
            pin_sample <= 1'h0;
        end else begin
            rel_prev <= i_release_pin;
            key_sample <= i_key_wake_pin;
            pin_sample <= i_release_pin;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            key_written <= 1'h0;
        end else if (wr_key_en) begin
            key_written <= 1'h1;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    wire key_low = |(key_en & ~i_key_wake_pin);

    sequence s_warm_run;
        o_warmup [*8] ##1 (!o_warmup && !o_stop_mode);
    endsequence

    sequence s_stop_hit;
        in_stop && !o_warmup;
    endsequence

    property p_four_keys;
        s_stop_hit and key_low |=> o_wake_req && !o_stop_mode;
    endproperty
    a_four_keys: assert property (p_four_keys)
        else $error("enabled key pin low did not release stop");

    property p_disabled_key;
        in_stop && !key_low && !i_release_pin |=> o_stop_mode;
    endproperty
    a_disabled_key: assert property (p_disabled_key)
        else $error("stop left with no release source");

    property p_en_write;
        wr_key_en |=> key_en == $past(i_avs_writedata[7:4]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable bits not taken from bits 7..4");

    property p_wo_read;
        i_avs_read && hit_key_en && !o_avs_waitrequest
            |-> o_avs_readdata == 32'h0000_0000;
    endproperty
    a_wo_read: assert property (p_wo_read)
        else $error("write only register read back nonzero");

    property p_en_reset;
        !key_written |-> key_en == 4'h0;
    endproperty
    a_en_reset: assert property (p_en_reset)
        else $error("key enables not cleared by reset");

    property p_key_wake;
        s_stop_hit and key_low |=> o_warmup ##0 stat[0];
    endproperty
    a_key_wake: assert property (p_key_wake)
        else $error("enabled key low did not wake");

    property p_level_pin;
        in_stop && level_mode && i_release_pin |=> o_warmup;
    endproperty
    a_level_pin: assert property (p_level_pin)
        else $error("high release pin did not wake in level mode");

    property p_edge_pin;
        in_stop && !level_mode && $rose(i_release_pin) |=> o_warmup;
    endproperty
    a_edge_pin: assert property (p_edge_pin)
        else $error("rising release pin did not wake in edge mode");

    property p_edge_hold;
        !level_mode && i_release_pin && $past(i_release_pin) &&
            !key_low |=> !o_wake_req;
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("steady high pin raised a request in edge mode");

    property p_skip;
        in_active && sleep_go && (i_release_pin || key_low)
            |=> o_warmup && !o_stop_mode && stat[1];
    endproperty
    a_skip: assert property (p_skip)
        else $error("stop entered despite release condition");

    property p_warm_len;
        $rose(o_warmup) |-> s_warm_run;
    endproperty
    a_warm_len: assert property (p_warm_len)
        else $error("warm-up length not eight cycles");

    property p_pin_no_enable;
        in_stop && level_mode && i_release_pin && key_en == 4'h0
            |=> o_warmup ##1 o_warmup;
    endproperty
    a_pin_no_enable: assert property (p_pin_no_enable)
        else $error("release pin ignored with keys disabled");

    property p_or_flag;
        in_stop && (i_release_pin || key_low) && level_mode
            |=> o_wake_req && o_warmup;
    endproperty
    a_or_flag: assert property (p_or_flag)
        else $error("release request missing its or term");

    property p_set_wins;
        ev_wake && wr_stat && wbyte[0] |=> stat[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("wake event lost to a clear");

endmodule

// >>> test/kwsr_key_model.sv
// model of the key switches and the release signal source
`timescale 1ns/1ps
module kwsr_key_model (
    input wire logic i_core_clk,
    input wire logic i_slow,
    input wire logic [3:0] i_press,
    input wire logic i_rel,
    output logic o_release_pin = 1'b0,
    output logic [3:0] o_key_wake_pin = 4'hf
);
    logic [3:0] lag_keys = 4'hf;
    logic lag_rel = 1'b0;

    // ****************************************
    // pins follow the commands one cycle late, or two cycles late when slow
    // ****************************************
    always @(posedge i_core_clk) begin
        lag_keys <= ~i_press;
        lag_rel <= i_rel;
        // an open key is pulled up, a pressed one pulls low
        o_key_wake_pin <= i_slow ? lag_keys : ~i_press;
        // the source holds low unless it asks for release
        o_release_pin <= i_slow ? lag_rel : i_rel;
    end
endmodule

// >>> test/kwsr_test.sv
// self-checking bench of the key wakeup stop release block
`timescale 1ns/1ps
module kwsr_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic rel_pin;
    logic [3:0] key_pin;
    logic stop;
    logic warm;
    logic wreq;
    logic irq;
    logic slow = 1'b0;
    logic [3:0] press = 4'h0;
    logic rel = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;

    always #12.5 clk = ~clk;

    kwsr_top kwsr_top_i (
        .i_core_clk(clk),
        .i_rst(rst),
        .i_avs_address(addr),
        .i_avs_read(rd),
        .i_avs_write(wr),
        .i_avs_writedata(wdat),
        .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq),
        .i_release_pin(rel_pin),
        .i_key_wake_pin(key_pin),
        .o_stop_mode(stop),
        .o_warmup(warm),
        .o_wake_req(wreq),
        .o_irq(irq)
    );

    kwsr_key_model kwsr_key_model_i (
        .i_core_clk(clk),
        .i_slow(slow),
        .i_press(press),
        .i_rel(rel),
        .o_release_pin(rel_pin),
        .o_key_wake_pin(key_pin)
    );

    // ****************************************
    // comparisons and verdict
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task chkb(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task complete_run;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // avalon master
    // ****************************************
    task xfer(input logic w, input logic [5:0] idx, input logic [31:0] d,
              output logic [31:0] q);
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdat <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task rdc(input string nm, input logic [5:0] idx, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, idx, 32'h0, q);
        chk(nm, e, q);
    endtask

    task wrt(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, idx, {24'h0, d}, q);
    endtask

    // stop entry: writes the sleep bit with the level bit set to lvl
    task sleep(input logic lvl);
        wrt(kwsr_pkg::IDX_CTRL, {6'h00, 1'b1, lvl});
    endtask

    // warm-up length, status, then interrupt raise and clear
    task woke(input logic [31:0] st, input logic ir);
        int n;
        int len;
        n = 0;
        while (warm !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        len = 0;
        while (warm === 1'b1 && len < 40) begin
            @(posedge clk);
            len++;
        end
        chk("warmup length", 32'(kwsr_pkg::WARM_CYC), 32'(len));
        chkb("stop mode", 1'b0, stop);
        rdc("status", kwsr_pkg::IDX_STAT, st);
        chkb("irq", ir, irq);
        wrt(kwsr_pkg::IDX_STAT, 8'h03);
        repeat (3) @(posedge clk);
        chkb("irq cleared", 1'b0, irq);
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc("key enable", kwsr_pkg::IDX_KEY_EN, 32'h0);
        rdc("control", kwsr_pkg::IDX_CTRL, 32'h1);
        rdc("unmapped", 6'h00, 32'h0);
        press <= 4'h1;
        sleep(1'b1);
        repeat (4) @(posedge clk);
        chkb("stop mode", 1'b1, stop);
        chkb("wake request", 1'b0, wreq);
        // slow pin lands the release on the status clear: the set must win
        slow <= 1'b1;
        rel <= 1'b1;
        wrt(kwsr_pkg::IDX_STAT, 8'h01);
        woke(32'h1, 1'b0);
        rel <= 1'b0;
        press <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            wrt(kwsr_pkg::IDX_KEY_EN, 8'(8'h10 << k));
            slow <= (k == 3);
            press <= 4'(4'h1 << ((k + 1) % 4));
            sleep(1'b1);
            repeat (4) @(posedge clk);
            chkb("stop mode", 1'b1, stop);
            press <= press | 4'(4'h1 << k);
            woke(32'h1, 1'b0);
            press <= 4'h0;
        end
        slow <= 1'b0;
        press <= 4'h8;
        repeat (4) @(posedge clk);
        chkb("wake request", 1'b1, wreq);
        sleep(1'b1);
        woke(32'h2, 1'b0);
        press <= 4'h0;
        wrt(kwsr_pkg::IDX_CTRL, 8'h00);
        rel <= 1'b1;
        sleep(1'b0);
        woke(32'h2, 1'b0);
        rel <= 1'b0;
        wrt(kwsr_pkg::IDX_KEY_EN, 8'h00);
        wrt(kwsr_pkg::IDX_MASK, 8'h01);
        rdc("control", kwsr_pkg::IDX_CTRL, 32'h0);
        sleep(1'b0);
        repeat (4) @(posedge clk);
        chkb("stop mode", 1'b1, stop);
        rdc("state", kwsr_pkg::IDX_STATE, 32'hf1);
        rel <= 1'b1;
        woke(32'h1, 1'b1);
        rel <= 1'b0;
        complete_run;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule
